// >>> logic/sfm_pkg.sv
// constants and types for the safety input minor fault monitor
// Contract
// - Report code 01H when pulse testing finds an input channel shorted to 24V or to another channel.
// - Report code 02H when the reset input stays on for more than 3 seconds.
// - Report code 04H when the light curtain stays muted longer than the configured mute limit.
// - Report code 05H when no mode selection input is active for more than 250 ms in a row.
// - Report code 06H when more than one mode selection input is active at once.
// - Clear the selection faults only after the selector has stepped through each valid mode in turn.
// - Report code 07H when hazard feedback falls to off while the unlock command is on.
// - Clear the hazardous motion fault when the lock request input is asserted.
// - Report code 08H when, after a reset, one channel of a dual input drops to safe and comes back.
// - Clear the pulse test, reset held, mute time and bounce faults only by power cycle or new configuration.
// - When several fault types are active, report the OR of their type values.
package sfm_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int RESET_HELD_MS = 3000;
    localparam int NO_SEL_MS = 250;
    localparam int RESET_HELD_CYC = CLK_HZ / 1000 * RESET_HELD_MS;
    localparam int NO_SEL_CYC = CLK_HZ / 1000 * NO_SEL_MS;
    localparam int MODE_W = 4;
    localparam int CNT_W = 32;
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_PULSE = 8'h01;
    localparam logic [7:0] CODE_RST_HELD = 8'h02;
    localparam logic [7:0] CODE_MUTE = 8'h04;
    localparam logic [7:0] CODE_NO_SEL = 8'h05;
    localparam logic [7:0] CODE_MULTI_SEL = 8'h06;
    localparam logic [7:0] CODE_HAZARD = 8'h07;
    localparam logic [7:0] CODE_BOUNCE = 8'h08;
    localparam logic [8:0] TYPE_BASE = 9'h010;
    localparam logic [8:0] TYPE_MUTE_SEQ = 9'h040;
    localparam logic [8:0] TYPE_CURTAIN_SEQ = 9'h080;
    localparam logic [8:0] TYPE_TIMING = 9'h004;
    typedef enum logic [1:0] {
        BNC_IDLE = 2'b00,
        BNC_ARMED = 2'b01,
        BNC_DROPPED = 2'b11
    } sfm_bounce_type;
endpackage

// >>> logic/sfm_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module sfm_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a change once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    dout[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule

// >>> logic/sfm_monitor.sv
// minor fault monitor for safety relay field inputs
`timescale 1ns/1ns
module sfm_monitor (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CONFIG_LOAD,
    input wire logic PULSE_TEST_FAIL,
    input wire logic RESET_INPUT,
    input wire logic MUTE_ACTIVE,
    input wire logic [sfm_pkg::CNT_W-1:0] MUTE_LIMIT_CYC,
    input wire logic [sfm_pkg::MODE_W-1:0] MODE_SEL,
    input wire logic HAZARD_FEEDBACK,
    input wire logic UNLOCK_CMD,
    input wire logic LOCK_REQUEST_INPUT,
    input wire logic CHAN_A,
    input wire logic CHAN_B,
    input wire logic SEQ_MUTE_FAULT,
    input wire logic SEQ_CURTAIN_FAULT,
    output logic [7:0] FAULT_CODE,
    output logic [8:0] FAULT_TYPE,
    output logic [7:0] FAULT_FLAGS
);
    localparam int NIN = 7 + sfm_pkg::MODE_W;

    logic [NIN-1:0] pins;
    logic [NIN-1:0] sync;
    logic pulse_s, rst_s, mute_s, haz_s, unl_s, lr_s, cha_s, chb_s;
    logic [sfm_pkg::MODE_W-1:0] mode_s;

    assign pins = {PULSE_TEST_FAIL, RESET_INPUT, MUTE_ACTIVE, HAZARD_FEEDBACK,
                   LOCK_REQUEST_INPUT, CHAN_A, CHAN_B, MODE_SEL};

    sfm_sync #(.W(NIN)) u_sync (
        .clk(CLK),
        .reset(RESET),
        .din(pins),
        .dout(sync)
    );

    assign {pulse_s, rst_s, mute_s, haz_s, lr_s, cha_s, chb_s, mode_s} = sync;
    // unlock command is the relay's own output, same clock
    assign unl_s = UNLOCK_CMD;

    function automatic logic [2:0] ones(input logic [sfm_pkg::MODE_W-1:0] v);
        logic [2:0] n;
        n = 3'd0;
        for (int k = 0; k < sfm_pkg::MODE_W; k++) begin
            n = n + {2'b00, v[k]};
        end
        return n;
    endfunction

    logic f_pulse_q, f_rst_q, f_mute_q, f_nosel_q, f_multi_q, f_haz_q, f_bnc_q;
    logic clear_cfg;
    assign clear_cfg = CONFIG_LOAD;

    // pulse test fault, latched until new configuration
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            f_pulse_q <= 1'b0;
        end else if (pulse_s) begin
            f_pulse_q <= 1'b1;
        end else if (clear_cfg) begin
            f_pulse_q <= 1'b0;
        end
    end

    // reset held timer
    logic [sfm_pkg::CNT_W-1:0] rst_cnt_q;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rst_cnt_q <= '0;
        end else if (!rst_s) begin
            rst_cnt_q <= '0;
        end else if (rst_cnt_q != sfm_pkg::CNT_W'(sfm_pkg::RESET_HELD_CYC)) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            f_rst_q <= 1'b0;
        end else if (rst_s && rst_cnt_q == sfm_pkg::CNT_W'(sfm_pkg::RESET_HELD_CYC)) begin
            f_rst_q <= 1'b1;
        end else if (clear_cfg) begin
            f_rst_q <= 1'b0;
        end
    end

    // mute duration timer
    logic [sfm_pkg::CNT_W-1:0] mute_cnt_q;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mute_cnt_q <= '0;
        end else if (!mute_s) begin
            mute_cnt_q <= '0;
        end else if (mute_cnt_q <= MUTE_LIMIT_CYC) begin
            mute_cnt_q <= mute_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            f_mute_q <= 1'b0;
        end else if (mute_s && mute_cnt_q > MUTE_LIMIT_CYC) begin
            f_mute_q <= 1'b1;
        end else if (clear_cfg) begin
            f_mute_q <= 1'b0;
        end
    end

    // mode selection checks
    logic [2:0] nsel;
    assign nsel = ones(mode_s);
    logic [sfm_pkg::CNT_W-1:0] nosel_cnt_q;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            nosel_cnt_q <= '0;
        end else if (nsel != 3'd0) begin
            nosel_cnt_q <= '0;
        end else if (nosel_cnt_q != sfm_pkg::CNT_W'(sfm_pkg::NO_SEL_CYC)) begin
            nosel_cnt_q <= nosel_cnt_q + 1'b1;
        end
    end

    // walk tracker: each valid mode must be seen alone, in order
    logic [sfm_pkg::MODE_W-1:0] walk_q;
    logic walk_done;
    assign walk_done = walk_q == {sfm_pkg::MODE_W{1'b1}};
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            walk_q <= '0;
        end else if (!(f_nosel_q || f_multi_q) || walk_done) begin
            walk_q <= '0;
        // next expected mode is the lowest bit not yet seen
        end else if (nsel == 3'd1 && mode_s == ((walk_q + 1'b1) & ~walk_q)) begin
            walk_q <= walk_q | mode_s;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            f_nosel_q <= 1'b0;
        end else if (nsel == 3'd0 && nosel_cnt_q == sfm_pkg::CNT_W'(sfm_pkg::NO_SEL_CYC)) begin
            f_nosel_q <= 1'b1;
        end else if (walk_done) begin
            f_nosel_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            f_multi_q <= 1'b0;
        end else if (nsel > 3'd1) begin
            f_multi_q <= 1'b1;
        end else if (walk_done) begin
            f_multi_q <= 1'b0;
        end
    end

    // hazardous motion while unlocked
    logic haz_prev_q;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            haz_prev_q <= 1'b0;
        end else begin
            haz_prev_q <= haz_s;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            f_haz_q <= 1'b0;
        end else if (haz_prev_q && !haz_s && unl_s) begin
            f_haz_q <= 1'b1;
        end else if (lr_s) begin
            f_haz_q <= 1'b0;
        end
    end

    // contact bounce: armed by a reset press, watch each channel
    sfm_pkg::sfm_bounce_type bnc_q;
    logic both_on;
    assign both_on = cha_s && chb_s;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bnc_q <= sfm_pkg::BNC_IDLE;
        end else begin
            case (bnc_q)
                sfm_pkg::BNC_IDLE: begin
                    if (rst_s && both_on) begin
                        bnc_q <= sfm_pkg::BNC_ARMED;
                    end
                end
                sfm_pkg::BNC_ARMED: begin
                    if (!cha_s && !chb_s) begin
                        bnc_q <= sfm_pkg::BNC_IDLE;
                    end else if (cha_s != chb_s) begin
                        bnc_q <= sfm_pkg::BNC_DROPPED;
                    end
                end
                sfm_pkg::BNC_DROPPED: begin
                    if (both_on || (!cha_s && !chb_s)) begin
                        bnc_q <= sfm_pkg::BNC_IDLE;
                    end
                end
                default: bnc_q <= sfm_pkg::BNC_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            f_bnc_q <= 1'b0;
        end else if (bnc_q == sfm_pkg::BNC_DROPPED && both_on) begin
            f_bnc_q <= 1'b1;
        end else if (clear_cfg) begin
            f_bnc_q <= 1'b0;
        end
    end

    // reported code: lowest numbered active fault
    logic [7:0] code_d;
    logic [8:0] type_d;
    always_comb begin
        if (f_pulse_q) code_d = sfm_pkg::CODE_PULSE;
        else if (f_rst_q) code_d = sfm_pkg::CODE_RST_HELD;
        else if (f_mute_q) code_d = sfm_pkg::CODE_MUTE;
        else if (f_nosel_q) code_d = sfm_pkg::CODE_NO_SEL;
        else if (f_multi_q) code_d = sfm_pkg::CODE_MULTI_SEL;
        else if (f_haz_q) code_d = sfm_pkg::CODE_HAZARD;
        else if (f_bnc_q) code_d = sfm_pkg::CODE_BOUNCE;
        else code_d = sfm_pkg::CODE_NONE;
        type_d = '0;
        if (code_d != sfm_pkg::CODE_NONE) type_d = type_d | sfm_pkg::TYPE_BASE;
        if (f_mute_q) type_d = type_d | sfm_pkg::TYPE_TIMING;
        if (SEQ_MUTE_FAULT) type_d = type_d | sfm_pkg::TYPE_MUTE_SEQ;
        if (SEQ_CURTAIN_FAULT) type_d = type_d | sfm_pkg::TYPE_CURTAIN_SEQ;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FAULT_CODE <= sfm_pkg::CODE_NONE;
            FAULT_TYPE <= '0;
            FAULT_FLAGS <= '0;
        end else begin
            FAULT_CODE <= code_d;
            FAULT_TYPE <= type_d;
            FAULT_FLAGS <= {1'b0, f_bnc_q, f_haz_q, f_multi_q, f_nosel_q, f_mute_q,
                            f_rst_q, f_pulse_q};
        end
    end
endmodule

// >>> bench/sfm_mon_chk_monitor.sv
// port assertions for the minor fault monitor
`timescale 1ns/1ns
module sfm_mon_chk (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CONFIG_LOAD,
    input wire logic [sfm_pkg::MODE_W-1:0] MODE_SEL,
    input wire logic HAZARD_FEEDBACK,
    input wire logic UNLOCK_CMD,
    input wire logic LOCK_REQUEST_INPUT,
    input wire logic SEQ_MUTE_FAULT,
    input wire logic [7:0] FAULT_CODE,
    input wire logic [8:0] FAULT_TYPE,
    input wire logic [7:0] FAULT_FLAGS
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_code_pulse: assert property (FAULT_FLAGS[0] |-> FAULT_CODE == 8'h01)
        else $error("pulse flag without code 01");
    a_code_bounce: assert property (FAULT_FLAGS == 8'h40 |-> FAULT_CODE == 8'h08)
        else $error("bounce flag without code 08");
    a_type_mute: assert property (FAULT_TYPE[2] == FAULT_FLAGS[2])
        else $error("mute type bit differs from mute flag");
    a_type_minor: assert property (FAULT_TYPE[4] == (|FAULT_FLAGS))
        else $error("minor type bit differs from flags");
    a_type_seq: assert property (SEQ_MUTE_FAULT [*3] |-> FAULT_TYPE[6])
        else $error("mute sequence type bit missing");
    a_multi_sel: assert property (($countones(MODE_SEL) > 1) [*8] |=> FAULT_FLAGS[4])
        else $error("multiple selection not flagged");
    a_hazard_set: assert property ($fell(HAZARD_FEEDBACK) && UNLOCK_CMD && !LOCK_REQUEST_INPUT
        ##1 (UNLOCK_CMD && !LOCK_REQUEST_INPUT && !HAZARD_FEEDBACK) [*8]
        |-> FAULT_FLAGS[5])
        else $error("hazardous motion not flagged");
    a_hazard_clear: assert property ((LOCK_REQUEST_INPUT && $stable(HAZARD_FEEDBACK)) [*8]
        |=> !FAULT_FLAGS[5])
        else $error("lock request did not clear hazard flag");
    a_pulse_sticky: assert property (FAULT_FLAGS[0] && !CONFIG_LOAD && !$past(CONFIG_LOAD)
        |=> FAULT_FLAGS[0])
        else $error("pulse flag dropped without clear");
endmodule

// >>> bench/sfm_field.sv
// field device model: mode selector and dual channel switch
`timescale 1ns/1ns
module sfm_field (
    input wire logic clk,
    input wire logic [2:0] cmd,
    output logic [sfm_pkg::MODE_W-1:0] mode_sel,
    output logic chan_a,
    output logic chan_b
);
    initial begin
        mode_sel = 4'h1;
        chan_a = 1'b0;
        chan_b = 1'b0;
    end
    always @(negedge clk) begin
        case (cmd)
            3'h1: mode_sel <= ($countones(mode_sel) != 1 || mode_sel == 4'h8) ? 4'h1
                : mode_sel << 1;
            3'h2: mode_sel <= 4'h3;
            3'h3: {chan_a, chan_b} <= 2'b11;
            3'h4: chan_a <= 1'b0;
            3'h5: mode_sel <= 4'h0;
            default: ;
        endcase
    end
endmodule

// >>> bench/testbench.sv
// self-checking bench for the minor fault monitor
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cfg = 1'b0, pulse = 1'b0, rst_in = 1'b0, mute = 1'b0, haz = 1'b1, unlock = 1'b0;
    logic lock = 1'b0, seq_m = 1'b0, seq_c = 1'b0;
    logic [2:0] cmd = 3'h0;
    logic [sfm_pkg::MODE_W-1:0] mode_sel;
    logic chan_a, chan_b;
    logic [8:0] f_type;
    logic [7:0] f_code, f_flags;
    int n_fail = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    sfm_field i_sfm_field (.clk(clk), .cmd(cmd), .mode_sel(mode_sel), .chan_a(chan_a),
        .chan_b(chan_b));
    sfm_monitor i_sfm_monitor (.CLK(clk), .RESET(reset), .CONFIG_LOAD(cfg),
        .PULSE_TEST_FAIL(pulse), .RESET_INPUT(rst_in), .MUTE_ACTIVE(mute),
        .MUTE_LIMIT_CYC(32'h14), .MODE_SEL(mode_sel), .HAZARD_FEEDBACK(haz),
        .UNLOCK_CMD(unlock), .LOCK_REQUEST_INPUT(lock), .CHAN_A(chan_a), .CHAN_B(chan_b),
        .SEQ_MUTE_FAULT(seq_m), .SEQ_CURTAIN_FAULT(seq_c), .FAULT_CODE(f_code),
        .FAULT_TYPE(f_type), .FAULT_FLAGS(f_flags));
    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string name, logic [8:0] seen, logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic expect_out(logic [7:0] fl, logic [7:0] cd);
        logic [8:0] ty;
        ty = (fl != 8'h00) ? sfm_pkg::TYPE_BASE : 9'h000;
        if (fl[2]) ty = ty | sfm_pkg::TYPE_TIMING;
        if (seq_m) ty = ty | sfm_pkg::TYPE_MUTE_SEQ;
        if (seq_c) ty = ty | sfm_pkg::TYPE_CURTAIN_SEQ;
        chk("flags", {1'b0, f_flags}, {1'b0, fl});
        chk("code", {1'b0, f_code}, {1'b0, cd});
        chk("type", f_type, ty);
    endtask
    task automatic cfg_pulse();
        cfg <= 1'b1;
        cyc(1);
        cfg <= 1'b0;
        cyc(4);
    endtask
    task automatic field(logic [2:0] c);
        cmd <= c;
        cyc(1);
        cmd <= 3'h0;
        cyc(12);
    endtask
    task automatic t_pulse();
        pulse <= 1'b1;
        cyc(12);
        pulse <= 1'b0;
        cyc(12);
        expect_out(8'h01, 8'h01);
        cfg_pulse();
        expect_out(8'h00, 8'h00);
    endtask
    task automatic t_mute();
        mute <= 1'b1;
        cyc(15);
        mute <= 1'b0;
        cyc(6);
        mute <= 1'b1;
        cyc(15);
        mute <= 1'b0;
        cyc(12);
        expect_out(8'h00, 8'h00);
        mute <= 1'b1;
        cyc(40);
        mute <= 1'b0;
        seq_m <= 1'b1;
        cyc(12);
        expect_out(8'h04, 8'h04);
        seq_c <= 1'b1;
        cyc(4);
        expect_out(8'h04, 8'h04);
        cfg_pulse();
        seq_m <= 1'b0;
        seq_c <= 1'b0;
        cyc(4);
        expect_out(8'h00, 8'h00);
    endtask
    task automatic t_sel();
        field(3'h2);
        expect_out(8'h10, 8'h06);
        repeat (3) field(3'h1);
        expect_out(8'h10, 8'h06);
        field(3'h1);
        expect_out(8'h00, 8'h00);
        field(3'h5);
        expect_out(8'h00, 8'h00);
        field(3'h1);
    endtask
    task automatic t_haz();
        unlock <= 1'b1;
        cyc(4);
        haz <= 1'b0;
        cyc(12);
        expect_out(8'h20, 8'h07);
        cfg_pulse();
        expect_out(8'h20, 8'h07);
        lock <= 1'b1;
        cyc(12);
        lock <= 1'b0;
        cyc(4);
        expect_out(8'h00, 8'h00);
        unlock <= 1'b0;
        haz <= 1'b1;
        cyc(12);
        haz <= 1'b0;
        cyc(12);
        expect_out(8'h00, 8'h00);
    endtask
    task automatic t_bounce();
        rst_in <= 1'b1;
        field(3'h3);
        expect_out(8'h00, 8'h00);
        rst_in <= 1'b0;
        field(3'h4);
        expect_out(8'h00, 8'h00);
        field(3'h3);
        expect_out(8'h40, 8'h08);
        reset <= 1'b1;
        cyc(3);
        reset <= 1'b0;
        cyc(2);
        expect_out(8'h00, 8'h00);
    endtask
    initial begin
        cyc(3);
        reset <= 1'b0;
        cyc(2);
        expect_out(8'h00, 8'h00);
        t_pulse();
        t_mute();
        t_sel();
        t_haz();
        t_bounce();
        end_of_test();
    end
    initial begin
        cyc(3000);
        n_fail++;
        end_of_test();
    end
endmodule
bind sfm_monitor sfm_mon_chk i_sfm_mon_chk (.CLK(CLK), .RESET(RESET),
    .CONFIG_LOAD(CONFIG_LOAD), .MODE_SEL(MODE_SEL), .HAZARD_FEEDBACK(HAZARD_FEEDBACK),
    .UNLOCK_CMD(UNLOCK_CMD), .LOCK_REQUEST_INPUT(LOCK_REQUEST_INPUT),
    .SEQ_MUTE_FAULT(SEQ_MUTE_FAULT), .FAULT_CODE(FAULT_CODE), .FAULT_TYPE(FAULT_TYPE),
    .FAULT_FLAGS(FAULT_FLAGS));
